// *** rtl/pbw_pkg.sv ***
// Purpose: shared constants and carriers for the pushbutton wiper stepper
// Assumes: 20 MHz system clock
// Notes: timing figures are kept in their own unit, counts derived here
package pbw_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int TAP_COUNT = 64;
    localparam int POS_W = 6;
    // Times as printed
    localparam int DEBOUNCE_MS = 1;
    localparam int GAP_MS = 1;
    localparam int HOLD_MS = 1000;
    localparam int REPEAT_MS = 100;
    localparam int IDLE_MS = 1000;
    localparam int STORE_MS = 2000;
    localparam int DETECT_US = 10;
    localparam int DIG_PULSE_US = 1;
    // Derived cycle counts (integer division truncates, no rounding up)
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int GAP_CYC = (CLK_HZ / 1000) * GAP_MS;
    localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    localparam int REPEAT_CYC = (CLK_HZ / 1000) * REPEAT_MS;
    localparam int IDLE_CYC = (CLK_HZ / 1000) * IDLE_MS;
    localparam int STORE_CYC = (CLK_HZ / 1000) * STORE_MS;
    localparam int DETECT_CYC = (CLK_HZ / 1000000) * DETECT_US;
    // Contact filter length over digital filter length
    localparam int DIG_RATIO = (DEBOUNCE_MS * 1000) / DIG_PULSE_US;
    // Endurance of the store
    localparam int WEAR_LIMIT = 80000;
    localparam logic [5:0] POS_RESET = 6'h00;
    localparam int CHG_BIT = 3; // fourth least significant bit

    // Step request from an input channel
    typedef struct packed {
        logic fire;   // one-cycle step request
        logic start;  // one-cycle first step of an activity
    } pbw_step_t;
endpackage

// *** rtl/pbw_nv_store.sv ***
// Purpose: small nonvolatile-style position store with wear counter
// Assumes: contents survive rst_b (no reset on the memory word)
// Notes: read data come from a register; writes stop landing after wear-out
`timescale 1ns/1ps
`default_nettype none
module pbw_nv_store #(
    parameter int POS_W = 6,
    parameter int WEAR_LIMIT = 80000
) (
    input wire logic clk,               // System clock
    input wire logic rst_b,             // Async reset, active low
    input wire logic ce,                // Clock enable
    input wire logic wrEn,              // Write strobe
    input wire logic [POS_W-1:0] wrData, // Position to record
    output logic [POS_W-1:0] rdData     // Registered recorded position
);
    initial begin
        if (POS_W < 1 || WEAR_LIMIT < 1) begin
            $error("pbw_nv_store: bad parameters");
        end
    end

    // ==========================================================
    // Cell and wear counter
    // ==========================================================
    logic [POS_W-1:0] cell_q = '0; // Blank store reads as tap zero
    logic [POS_W-1:0] cell_d;
    logic [31:0] wear_q, wear_d;
    logic [POS_W-1:0] rd_q, rd_d;

    // Worn cells keep their last content, device still runs
    always_comb begin
        cell_d = cell_q;
        wear_d = wear_q;
        rd_d = cell_q;
        if (wrEn && wear_q < 32'(WEAR_LIMIT)) begin
            cell_d = wrData;
            wear_d = wear_q + 32'h1;
        end
    end

    // Cell is not reset: it models retention across power loss
    always_ff @(posedge clk) begin
        if (ce) begin
            cell_q <= cell_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wear_q <= 32'h0;
            rd_q <= '0;
        end else if (ce) begin
            wear_q <= wear_d;
            rd_q <= rd_d;
        end
    end

    assign rdData = rd_q;
endmodule
`default_nettype wire

// *** rtl/pbw_wiper_ctrl.sv ***
// Purpose: pulse-width driven 64-tap wiper stepper with position store
// Assumes: inputs synchronous to clk; rst_b is the power-on event
// Notes: analogue ladder not modelled; wiper position is the output
`timescale 1ns/1ps
`default_nettype none
module pbw_wiper_ctrl #(
    parameter int DEB_CYC = pbw_pkg::DEBOUNCE_CYC,
    parameter int HOLD_CYC = pbw_pkg::HOLD_CYC,
    parameter int REP_CYC = pbw_pkg::REPEAT_CYC,
    parameter int IDLE_CYC = pbw_pkg::IDLE_CYC,
    parameter int STORE_CYC = pbw_pkg::STORE_CYC
) (
    input wire logic clk,            // System clock, 20 MHz
    input wire logic rst_b,          // Power-on reset, active low
    input wire logic ce,             // Clock enable, freezes all state
    input wire logic upContactN,     // Up contact input, active low
    input wire logic downContactN,   // Down contact input, active low
    input wire logic digitalStepN,   // Digital step input, active low
    output logic [5:0] wiperPos,     // Wiper tap, 0..63
    output logic singleMode,         // High in single-button mode
    output logic modeValid,          // Mode detection complete
    output logic storeBusy           // Store write pending
);
    initial begin
        if (DEB_CYC < 1 || HOLD_CYC < 1 || REP_CYC < 1 || IDLE_CYC < 1
            || STORE_CYC < 1) begin
            $error("pbw_wiper_ctrl: counts must be positive");
        end
    end

    typedef enum logic [1:0] {ST_LOAD, ST_DETECT, ST_RUN} pbw_state_t;

    // Digital line accepts a low after the shorter least pulse width
    localparam int DIG_CYC = (DEB_CYC >= pbw_pkg::DIG_RATIO)
        ? DEB_CYC / pbw_pkg::DIG_RATIO : 1;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Saturating count-up toward a limit
    function automatic logic [31:0] cnt_up(input logic [31:0] c,
                                           input int lim);
        return (c < 32'(lim)) ? c + 32'h1 : c;
    endfunction

    // Channel step engine: pulse start, hold and repeat timing
    function automatic logic [31:0] hold_next(input logic act,
                                              input logic [31:0] c);
        return act ? c + 32'h1 : 32'h0;
    endfunction

    function automatic logic rep_fire(input logic act,
                                      input logic [31:0] c);
        logic [31:0] t;
        t = 32'h0;
        if (!act) begin
            return 1'b0;
        end
        if (c == 32'h0) begin
            return 1'b1;
        end
        if (c < 32'(HOLD_CYC)) begin
            return 1'b0;
        end
        t = c - 32'(HOLD_CYC);
        return (t % 32'(REP_CYC)) == 32'(REP_CYC - 1);
    endfunction

    // Short low on the digital line; every release keeps the full gap
    function automatic logic [31:0] deb_lim(input int ch,
                                            input logic low);
        return (ch == 2 && low) ? 32'(DIG_CYC - 1)
                                : 32'(DEB_CYC - 1);
    endfunction

    // ==========================================================
    // Debounce and pulse-merge filters
    // ==========================================================
    // Apart from a digital low (DIG_CYC), a level is accepted only after it stays steady for DEB_CYC, so
    // contact bounce and gaps under 1 ms never form new pulses
    logic [2:0] rawAct;
    logic [2:0] act_q, act_d;
    logic [31:0] deb_q [3], deb_d [3];
    assign rawAct = {~digitalStepN, ~downContactN, ~upContactN};

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            act_d[i] = act_q[i];
            deb_d[i] = 32'h0;
            if (rawAct[i] != act_q[i]) begin
                deb_d[i] = deb_q[i] + 32'h1;
                if (deb_q[i] >= deb_lim(i, rawAct[i])) begin
                    act_d[i] = rawAct[i];
                    deb_d[i] = 32'h0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_q <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                deb_q[i] <= 32'h0;
            end
        end else if (ce) begin
            act_q <= act_d;
            deb_q <= deb_d;
        end
    end

    // ==========================================================
    // Hold timers and step requests per channel
    // ==========================================================
    logic [31:0] hold_q [3], hold_d [3];
    pbw_pkg::pbw_step_t req [3];

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            hold_d[i] = hold_next(act_q[i], hold_q[i]);
            req[i].fire = rep_fire(act_q[i], hold_q[i]);
            req[i].start = act_q[i] && hold_q[i] == 32'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 3; i++) begin
                hold_q[i] <= 32'h0;
            end
        end else if (ce) begin
            hold_q <= hold_d;
        end
    end

    // ==========================================================
    // Power-up, mode detection and wiper movement
    // ==========================================================
    logic [5:0] pos_q, pos_d;
    logic dirUp_q, dirUp_d;
    logic single_q, single_d;
    logic valid_q, valid_d;
    logic [31:0] idle_q, idle_d;
    logic [2:0] det_q, det_d;
    pbw_state_t st_q, st_d;
    logic [5:0] nvRd;

    // Digital stream shares the single-button direction rules; it is
    // faster only because its filter takes a much shorter low, while
    // gaps still need the full contact filter so pulses stay separate
    always_comb begin
        logic anyFire;
        logic oneFire;
        logic oneStart;
        anyFire = 1'b0;
        oneFire = 1'b0;
        oneStart = 1'b0;
        pos_d = pos_q;
        dirUp_d = dirUp_q;
        single_d = single_q;
        valid_d = valid_q;
        st_d = st_q;
        det_d = det_q;
        idle_d = idle_q;
        case (st_q)
            ST_LOAD: begin
                // Wait one cycle for the registered store read
                st_d = ST_DETECT;
            end
            ST_DETECT: begin
                pos_d = nvRd;
                // Down tied high (inactive) at power-up: single mode
                single_d = downContactN;
                det_d = det_q + 3'h1;
                if (det_q == 3'h3) begin
                    valid_d = 1'b1;
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // Single-direction stream: up contact (single) and digital
                oneFire = req[2].fire || (single_q && req[0].fire);
                oneStart = req[2].start || (single_q && req[0].start);
                anyFire = act_q[2] || (single_q && act_q[0]);
                idle_d = anyFire ? 32'h0 : cnt_up(idle_q, IDLE_CYC);
                if (!single_q && req[0].fire) begin
                    pos_d = (pos_q == 6'h3F) ? pos_q : pos_q + 6'h1;
                    dirUp_d = 1'b1;
                end else if (!single_q && req[1].fire) begin
                    pos_d = (pos_q == 6'h00) ? pos_q : pos_q - 6'h1;
                    dirUp_d = 1'b0;
                end else if (oneFire) begin
                    logic up;
                    up = dirUp_q;
                    // New activity after idle runs opposite to last
                    if (oneStart && idle_q >= 32'(IDLE_CYC)) begin
                        up = ~dirUp_q;
                    end
                    // At an end, turn around instead of wrapping
                    if (up && pos_q == 6'h3F) begin
                        up = 1'b0;
                    end else if (!up && pos_q == 6'h00) begin
                        up = 1'b1;
                    end
                    pos_d = up ? pos_q + 6'h1 : pos_q - 6'h1;
                    dirUp_d = up;
                end
            end
            default: st_d = ST_LOAD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_q <= pbw_pkg::POS_RESET;
            dirUp_q <= 1'b0;
            single_q <= 1'b0;
            valid_q <= 1'b0;
            idle_q <= 32'(IDLE_CYC);
            det_q <= 3'h0;
            st_q <= ST_LOAD;
        end else if (ce) begin
            pos_q <= pos_d;
            dirUp_q <= dirUp_d;
            single_q <= single_d;
            valid_q <= valid_d;
            idle_q <= idle_d;
            det_q <= det_d;
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Store update policy
    // ==========================================================
    // Timer restarts on each move, so a write lands only after the
    // wiper has rested for the full delay; fewer writes, less wear
    logic [5:0] stored_q, stored_d;
    logic first_q, first_d;
    logic pend_q, pend_d;
    logic [31:0] stc_q, stc_d;
    logic nvWr;

    always_comb begin
        stored_d = stored_q;
        first_d = first_q;
        pend_d = pend_q;
        stc_d = stc_q;
        nvWr = 1'b0;
        if (st_q == ST_DETECT) begin
            stored_d = nvRd;
        end else if (st_q == ST_RUN) begin
            if (pos_d != pos_q) begin
                stc_d = 32'h0;
                // First change always; later only on coarse move
                pend_d = first_q
                    || (pos_d[5:pbw_pkg::CHG_BIT]
                        != stored_q[5:pbw_pkg::CHG_BIT]);
            end else if (pend_q) begin
                stc_d = cnt_up(stc_q, STORE_CYC);
                if (stc_q >= 32'(STORE_CYC - 1)) begin
                    nvWr = 1'b1;
                    pend_d = 1'b0;
                    first_d = 1'b0;
                    stored_d = pos_q;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stored_q <= pbw_pkg::POS_RESET;
            first_q <= 1'b1;
            pend_q <= 1'b0;
            stc_q <= 32'h0;
        end else if (ce) begin
            stored_q <= stored_d;
            first_q <= first_d;
            pend_q <= pend_d;
            stc_q <= stc_d;
        end
    end

    pbw_nv_store #(
        .POS_W(pbw_pkg::POS_W),
        .WEAR_LIMIT(pbw_pkg::WEAR_LIMIT)
    ) u_store (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .wrEn(nvWr),
        .wrData(pos_q),
        .rdData(nvRd)
    );

    assign wiperPos = pos_q;
    assign singleMode = single_q;
    assign modeValid = valid_q;
    assign storeBusy = pend_q;
endmodule
`default_nettype wire

// *** test/pbw_wiper_checker.sv ***
// Purpose: port assertions for the pushbutton wiper stepper
// Assumes: one clock domain, rst_b asynchronous and active low
// Notes: run-length counters let the debounce filter settle first
`timescale 1ns/1ps
`default_nettype none
module pbw_wiper_checker #(
    parameter int DEB_CYC = 4,
    parameter int REP_CYC = 8,
    parameter int STORE_CYC = 50
) (
    input wire logic clk,            // System clock
    input wire logic rst_b,          // Reset, active low
    input wire logic ce,             // Clock enable
    input wire logic upContactN,     // Up contact
    input wire logic downContactN,   // Down contact
    input wire logic digitalStepN,   // Digital step
    input wire logic [5:0] wiperPos, // Wiper tap
    input wire logic singleMode,     // Mode flag
    input wire logic modeValid,      // Detection done
    input wire logic storeBusy       // Store pending
);
    // ==========================================================
    // Helper counters
    logic allHi, udHi, upLo, dnLo;
    logic [7:0] quietAll, quietUd, upOnly, dnOnly, still;
    assign allHi = upContactN & downContactN & digitalStepN;
    assign udHi = upContactN & digitalStepN;
    assign upLo = !upContactN & downContactN & digitalStepN;
    assign dnLo = upContactN & !downContactN & digitalStepN;
    function automatic logic [7:0] inc(input logic [7:0] x);
        return (x == 8'hFF) ? x : x + 8'h01;
    endfunction
    // Saturating run lengths, so a long idle never wraps to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            quietAll <= 8'h00;
            quietUd <= 8'h00;
            upOnly <= 8'h00;
            dnOnly <= 8'h00;
            still <= 8'h00;
        end else if (ce) begin
            quietAll <= allHi ? inc(quietAll) : 8'h00;
            quietUd <= udHi ? inc(quietUd) : 8'h00;
            upOnly <= upLo ? inc(upOnly) : 8'h00;
            dnOnly <= dnLo ? inc(dnOnly) : 8'h00;
            still <= $stable(wiperPos) ? inc(still) : 8'h00;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_one_tap: assert property (
        modeValid && $past(modeValid) |-> wiperPos == $past(wiperPos)
        || wiperPos == $past(wiperPos) + 6'h01
        || wiperPos == $past(wiperPos) - 6'h01)
        else $error("wiper moved more than one tap");
    a_idle_still: assert property (
        modeValid && quietAll > DEB_CYC + 3 |-> $stable(wiperPos))
        else $error("wiper moved with all inputs high");
    a_single_mute: assert property (
        modeValid && singleMode && quietUd > DEB_CYC + 3
        |-> $stable(wiperPos))
        else $error("down input moved wiper in single mode");
    a_dual_up: assert property (
        modeValid && !singleMode && upOnly > DEB_CYC + 3
        |-> wiperPos >= $past(wiperPos))
        else $error("up press lowered wiper");
    a_dual_down: assert property (
        modeValid && !singleMode && dnOnly > DEB_CYC + 3
        |-> wiperPos <= $past(wiperPos))
        else $error("down press raised wiper");
    a_detect_time: assert property (
        $rose(rst_b) |-> ##[0:200] modeValid)
        else $error("mode detection too slow");
    a_mode_held: assert property (
        modeValid && $past(modeValid) |-> $stable(singleMode))
        else $error("mode changed while powered");
    a_repeat_gap: assert property (
        modeValid && upOnly > DEB_CYC + 3 && !$stable(wiperPos)
        |-> $past(still) >= REP_CYC - 2)
        else $error("held steps closer than repeat period");
    a_store_wait: assert property (
        $fell(storeBusy) |-> $past(still) >= STORE_CYC - 3)
        else $error("store written before settle delay");
    a_store_bound: assert property (
        still == STORE_CYC + 5 |-> !storeBusy)
        else $error("store write overdue");
endmodule
bind pbw_wiper_ctrl pbw_wiper_checker #(
    .DEB_CYC(DEB_CYC),
    .REP_CYC(REP_CYC),
    .STORE_CYC(STORE_CYC)
) pbw_wiper_checker_i (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .upContactN(upContactN),
    .downContactN(downContactN),
    .digitalStepN(digitalStepN),
    .wiperPos(wiperPos),
    .singleMode(singleMode),
    .modeValid(modeValid),
    .storeBusy(storeBusy)
);
`default_nettype wire

// *** test/pbw_button_model.sv ***
// Purpose: pushbuttons and processor line in front of the stepper
// Assumes: presses change only at falling clock edges
// Notes: floating down line reads low until detection, then pull-up
`timescale 1ns/1ps
`default_nettype none
module pbw_button_model (
    input wire logic clk,        // System clock
    input wire logic dualWiring, // Down line floats at power-up
    input wire logic powered,    // Detection finished
    output logic upContactN,     // Up contact, active low
    output logic downContactN,   // Down contact, active low
    output logic digitalStepN    // Digital step, active low
);
    logic upLow = 1'b0;
    logic dnLow = 1'b0;
    logic digLow = 1'b0;
    // Open-drain down line floats at power-up; the probe reads it low
    assign upContactN = !upLow;
    assign downContactN = dnLow ? 1'b0 :
        (dualWiring && !powered) ? 1'b0 : 1'b1;
    assign digitalStepN = !digLow;
    // Hold one line low, then leave all high for the gap
    task automatic press(input int which, input int lowCyc,
        input int highCyc);
        @(negedge clk);
        upLow = (which == 0);
        dnLow = (which == 1);
        digLow = (which == 2);
        repeat (lowCyc) @(negedge clk);
        upLow = 1'b0;
        dnLow = 1'b0;
        digLow = 1'b0;
        repeat (highCyc) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** test/test_pbw_wiper_ctrl.sv ***
// Purpose: self-checking bench for the wiper stepper
// Assumes: shortened counts, store survives rst_b
// Notes: first session starts from a blank store at tap zero
`timescale 1ns/1ps
`default_nettype none
module test_pbw_wiper_ctrl;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic dualWiring = 1'b1;
    wire logic upN;
    wire logic dnN;
    wire logic digN;
    logic [5:0] wiperPos;
    logic singleMode;
    logic modeValid;
    logic storeBusy;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // ==========================================================
    // Design and button model
    pbw_wiper_ctrl #(.DEB_CYC(4), .HOLD_CYC(40), .REP_CYC(8),
        .IDLE_CYC(40), .STORE_CYC(50)) pbw_wiper_ctrl_i (
        .clk(clk), .rst_b(rst_b), .ce(ce), .upContactN(upN),
        .downContactN(dnN), .digitalStepN(digN),
        .wiperPos(wiperPos), .singleMode(singleMode),
        .modeValid(modeValid), .storeBusy(storeBusy));
    pbw_button_model pbw_button_model_i (
        .clk(clk), .dualWiring(dualWiring), .powered(modeValid),
        .upContactN(upN), .downContactN(dnN), .digitalStepN(digN));
    // 20 MHz clock; hang guard well above the planned run
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            final_report();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic final_report();
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic press(input int w, input int lo, input int hi);
        pbw_button_model_i.press(w, lo, hi);
    endtask
    task automatic pos(input logic [5:0] exp);
        check("wiperPos", {2'h0, wiperPos}, {2'h0, exp});
    endtask
    // Power cycle with chosen wiring; reset held ten cycles
    task automatic power_up(input logic dual);
        int n = 0;
        @(negedge clk);
        dualWiring = dual;
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        while (modeValid !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check("modeValid", {7'h00, modeValid}, 8'h01);
        check("singleMode", {7'h00, singleMode}, {7'h00, !dual});
    endtask
    // ==========================================================
    // Scenarios
    task automatic dual_steps();
        logic [5:0] p;
        power_up(1'b1);
        press(1, 700, 10);
        pos(6'h00);
        press(0, 10, 10);
        pos(6'h01);
        press(1, 10, 10);
        pos(6'h00);
        press(0, 10, 1);
        press(0, 10, 10);
        pos(6'h01);
        press(0, 70, 10);
        pos(6'h05);
        repeat (3) press(0, 10, 10);
        pos(6'h08);
        repeat (80) @(negedge clk);
        check("storeBusy", {7'h00, storeBusy}, 8'h00);
        press(0, 10, 80);
        p = wiperPos;
        press(2, 10, 80);
        pos(p - 6'h01);
        press(0, 2, 10);
        pos(6'h08);
        press(2, 2, 80);
        pos(6'h09);
    endtask
    task automatic single_steps();
        power_up(1'b0);
        pos(6'h08);
        press(0, 10, 80);
        pos(6'h09);
        power_up(1'b0);
        pos(6'h09);
        press(0, 10, 80);
        pos(6'h0A);
        press(0, 10, 10);
        pos(6'h09);
        press(0, 10, 10);
        pos(6'h08);
        press(1, 10, 10);
        pos(6'h08);
        repeat (10) press(2, 10, 10);
        pos(6'h02);
        repeat (80) @(negedge clk);
        power_up(1'b0);
        pos(6'h02);
    endtask
    initial begin
        dual_steps();
        single_steps();
        final_report();
    end
endmodule
`default_nettype wire
